//--- eie_defs.svh
// Holds every offset and field position, the control reset value and the code limits of the exit information encoder.
// Assumes inclusion by bare name from the package and the design module.
`ifndef EIE_DEFS_SVH
`define EIE_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define EIE_OFS_INFO       4'h0
`define EIE_OFS_CTRL       4'h4
`define EIE_OFS_STATUS     4'h8

// Control register bits and reset value.
`define EIE_CTRL_CAPTURE   0
`define EIE_CTRL_ZERO      1
`define EIE_CTRL_RESET     2'h3

// Status register bits.
`define EIE_STAT_BAD       0
`define EIE_STAT_LAYOUT    1
`define EIE_STAT_CNT_LSB   8

// Field positions in the information word.
`define EIE_POS_SCALE      0
`define EIE_POS_ASIZE      7
`define EIE_POS_MEMREG     10
`define EIE_POS_OPSIZE     11
`define EIE_POS_SEG        15
`define EIE_POS_INDEX      18
`define EIE_POS_IDXBAD     22
`define EIE_POS_BASE       23
`define EIE_POS_BASEBAD    27
`define EIE_POS_SECOND_REGISTER_FIELD       28
`define EIE_POS_IDENT      28

// Largest legal codes and the lowest fallback codes.
`define EIE_ASIZE_16       2'h0
`define EIE_ASIZE_64       2'h2
`define EIE_SCALE_8        2'h3
`define EIE_SEG_LAST       3'h5
`define EIE_SEG_ES         3'h0

`endif

//--- eie_exit_instr_info_encoder.sv
// Holds the encoder that builds the instruction-information word at an exit, with its Wishbone slave.
// Assumes decoder inputs are on ref_clk and that a classic Wishbone master reads the result.
`include "eie_defs.svh"

module eie_exit_instr_info_encoder
  import eie_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        exitStrobe,
  input  wire eie_dec_type decIn,
  input  wire logic        longMode,
  input  wire logic        wideCapable,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [31:0] infoWord,
  output logic             infoValid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Places a field at its bit position in a 32-bit word.
  function automatic logic [31:0] placeField(input logic [31:0] value, input int lsb);
    placeField = value << lsb;
  endfunction : placeField

  // Drops the top bit of a register number on parts without the extended registers.
  function automatic logic [3:0] legalReg(input logic [3:0] code, input logic wide);
    legalReg = wide ? code : {1'b0, code[2:0]};
  endfunction : legalReg

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode.

  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;
  logic        bad_reg;
  logic        bad_next;
  logic        layout_reg;
  logic [7:0]  count_reg;
  logic [31:0] infoWord_reg;
  logic [31:0] infoWord_next;
  logic        infoValid_reg;
  logic        ack_reg;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;

  // Bus request decode; one access per strobe, answered in the following cycle.
  wire busReq     = wb_cyc_i && wb_stb_i && !ack_reg;
  wire busWrite   = busReq && wb_we_i;
  wire hitInfo    = wb_adr_i == `EIE_OFS_INFO;
  wire hitCtrl    = wb_adr_i == `EIE_OFS_CTRL;
  wire hitStatus  = wb_adr_i == `EIE_OFS_STATUS;
  wire ctrlWrite  = busWrite && hitCtrl && wb_sel_i[0];
  wire badClear   = busWrite && hitStatus && wb_sel_i[0] && wb_dat_i[`EIE_STAT_BAD];
  wire captureEn  = ctrl_reg[`EIE_CTRL_CAPTURE];
  wire zeroUndef  = ctrl_reg[`EIE_CTRL_ZERO];
  wire captureNow = exitStrobe && captureEn;

  ////////////////////////////////////////////////////////////////////////////////
  // Code sanitising: only documented codes ever leave the block.

  wire asizeBad = decIn.addrSize > `EIE_ASIZE_64 || (decIn.addrSize == `EIE_ASIZE_64 && !wideCapable);
  wire scaleBad = decIn.scale == `EIE_SCALE_8 && !wideCapable;
  wire segBad   = decIn.segment > `EIE_SEG_LAST;
  wire regBad   = !wideCapable && (decIn.index_register_field[3] || decIn.base_register_field[3] || decIn.second_register_field[3]);
  wire anyBad   = asizeBad || scaleBad || segBad || regBad;

  // Illegal size, scale and segment codes fall back to the lowest code, register codes lose their top bit; the status flag records it.
  wire [1:0] asizeCode = asizeBad ? `EIE_ASIZE_16 : decIn.addrSize;
  wire [1:0] scaleCode = scaleBad ? 2'h0 : decIn.scale;
  wire [2:0] segCode   = segBad ? `EIE_SEG_ES : decIn.segment;
  wire [3:0] indexCode = legalReg(decIn.index_register_field, wideCapable);
  wire [3:0] baseCode  = legalReg(decIn.base_register_field, wideCapable);
  wire [3:0] reg2Code  = legalReg(decIn.second_register_field, wideCapable);

  // Undefined fields are either passed through or forced to zero under control.
  wire       idxQuiet   = zeroUndef && !decIn.indexValid;
  wire       baseQuiet  = zeroUndef && !decIn.baseValid;
  wire [1:0] scaleOut   = idxQuiet ? 2'h0 : scaleCode;
  wire [3:0] indexOut   = idxQuiet ? 4'h0 : indexCode;
  wire [3:0] baseOut    = baseQuiet ? 4'h0 : baseCode;
  wire       opSizeOut  = (zeroUndef && longMode) ? 1'b0 : decIn.opSize32;

  ////////////////////////////////////////////////////////////////////////////////
  // Word assembly for both layouts.

  // Fields common to both layouts, including the validity flags.
  wire [31:0] commonWord = placeField(32'(scaleOut), `EIE_POS_SCALE)
                         | placeField(32'(asizeCode), `EIE_POS_ASIZE)
                         | placeField(32'(segCode), `EIE_POS_SEG)
                         | placeField(32'(indexOut), `EIE_POS_INDEX)
                         | placeField(32'(!decIn.indexValid), `EIE_POS_IDXBAD)
                         | placeField(32'(baseOut), `EIE_POS_BASE)
                         | placeField(32'(!decIn.baseValid), `EIE_POS_BASEBAD);

  // Invalidation layout adds the second register on top.
  wire [31:0] invalWord = commonWord | placeField(32'(reg2Code), `EIE_POS_SECOND_REGISTER_FIELD);

  // Descriptor-table layout: operand size and identity; bit 10 stays zero.
  wire [31:0] dtabWord = commonWord
                       | placeField(32'(opSizeOut), `EIE_POS_OPSIZE)
                       | placeField(32'(decIn.dtabInstr), `EIE_POS_IDENT);

  wire isDtab = decIn.layout == EIE_LAYOUT_DTAB;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Layout choice follows the instruction family of the exit.
  always_comb begin
    infoWord_next = infoWord_reg;
    if (captureNow) begin
      infoWord_next = isDtab ? dtabWord : invalWord;
    end
  end

  // Control updates and the sticky error flag, whose set beats a clear.
  always_comb begin
    ctrl_next = ctrlWrite ? wb_dat_i[1:0] : ctrl_reg;
    bad_next  = bad_reg;
    if (badClear) begin
      bad_next = 1'b0;
    end
    if (captureNow && anyBad) begin
      bad_next = 1'b1;
    end
  end

  // Read data multiplexer; unmapped offsets read as zero.
  always_comb begin
    rdData_next = 32'h0;
    if (hitInfo) begin
      rdData_next = infoWord_reg;
    end else if (hitCtrl) begin
      rdData_next = {30'h0, ctrl_reg};
    end else if (hitStatus) begin
      rdData_next = placeField(32'(count_reg), `EIE_STAT_CNT_LSB)
                  | placeField(32'(layout_reg), `EIE_STAT_LAYOUT)
                  | placeField(32'(bad_reg), `EIE_STAT_BAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  // Encoder result and capture bookkeeping.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      infoWord_reg  <= 32'h0;
      infoValid_reg <= 1'b0;
      layout_reg    <= 1'b0;
      count_reg     <= 8'h0;
    end else begin
      infoWord_reg  <= infoWord_next;
      infoValid_reg <= captureNow;
      if (captureNow) begin
        layout_reg <= isDtab;
        count_reg  <= count_reg + 8'h1;
      end
    end
  end

  // Control, status and bus answer.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg   <= `EIE_CTRL_RESET;
      bad_reg    <= 1'b0;
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      bad_reg    <= bad_next;
      ack_reg    <= busReq;
      rdData_reg <= busReq ? rdData_next : rdData_reg;
    end
  end

  // Outputs straight from flip-flops.
  assign infoWord  = infoWord_reg;
  assign infoValid = infoValid_reg;
  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdData_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Helper copies of the captured inputs, read only by the checks.
  wire capDtab  = captureNow && isDtab;
  wire capInval = captureNow && !isDtab;
  wire capFull  = captureNow && wideCapable;

  index_field_a : assert property (capFull && decIn.indexValid && !zeroUndef |=>
    infoWord[21:18] == $past(decIn.index_register_field)) else $error("index register field wrong");
  index_quiet_a : assert property (captureNow && zeroUndef && !decIn.indexValid |=>
    infoWord[21:18] == 4'h0 && infoWord[1:0] == 2'h0) else $error("undefined index fields not zero");
  index_flag_a : assert property (captureNow |=>
    infoWord[22] == !$past(decIn.indexValid)) else $error("index invalid flag wrong");
  base_field_a : assert property (capFull && decIn.baseValid |=>
    infoWord[26:23] == $past(decIn.base_register_field)) else $error("base register field wrong");
  base_quiet_a : assert property (captureNow && zeroUndef && !decIn.baseValid |=>
    infoWord[26:23] == 4'h0) else $error("undefined base field not zero");
  base_flag_a : assert property (captureNow |=>
    infoWord[27] == !$past(decIn.baseValid)) else $error("base invalid flag wrong");
  second_register_field_field_a : assert property (capInval && wideCapable |=>
    infoWord[31:28] == $past(decIn.second_register_field)) else $error("second register field wrong");
  layout_pick_a : assert property (captureNow |=>
    layout_reg == $past(isDtab) && infoValid) else $error("layout not recorded");
  scale_field_a : assert property (capFull && decIn.indexValid |=>
    infoWord[1:0] == $past(decIn.scale)) else $error("scaling field wrong");
  addr_code_a : assert property (captureNow |=> infoWord[9:7] <= 3'h2 &&
    ($past(wideCapable) || infoWord[9:7] != 3'h2)) else $error("illegal address size code");
  memreg_zero_a : assert property (capDtab |=> infoWord[10] == 1'b0 &&
    infoWord[31:30] == 2'h0) else $error("descriptor layout bit 10 set");
  op_size_a : assert property (capDtab && !longMode |=>
    infoWord[11] == $past(decIn.opSize32)) else $error("operand size bit wrong");
  seg_code_a : assert property (infoValid |-> infoWord[17:15] <= 3'h5) else $error("illegal segment code");
  dtab_ident_a : assert property (capDtab |=>
    infoWord[29:28] == $past(decIn.dtabInstr)) else $error("instruction identity wrong");
  hold_word_a : assert property (!captureNow |=> $stable(infoWord)) else $error("word changed without exit");
  bad_sticky_a : assert property (captureNow && anyBad |=> bad_reg) else $error("bad code not flagged");

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, bookkeeping and sanitising checks.

  // A taken request is answered in the next cycle.
  ack_answer_a : assert property (busReq |=> wb_ack_o)
    else $error("request not acknowledged");

  // Acknowledge never comes without a taken request.
  ack_cause_a : assert property (!busReq |=> !wb_ack_o)
    else $error("acknowledge without request");

  // Acknowledge lasts exactly one cycle.
  ack_pulse_a : assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // Read data holds between taken accesses.
  rd_hold_a : assert property (!busReq |=> $stable(wb_dat_o))
    else $error("read data changed without access");

  // A capture raises the valid pulse.
  valid_rise_a : assert property (captureNow |=> infoValid)
    else $error("valid pulse missing");

  // No capture means no valid pulse.
  valid_quiet_a : assert property (!captureNow |=> !infoValid)
    else $error("valid pulse without capture");

  // Each capture steps the counter by one, with wrap.
  count_step_a : assert property (captureNow |=> count_reg == $past(count_reg) + 8'h1)
    else $error("capture count did not step");

  // The counter holds between captures.
  count_hold_a : assert property (!captureNow |=> $stable(count_reg))
    else $error("capture count changed");

  // A control write lands the low byte lane bits.
  ctrl_write_a : assert property (ctrlWrite |=> ctrl_reg == $past(wb_dat_i[1:0]))
    else $error("control write lost");

  // Control holds without a write on lane 0.
  ctrl_hold_a : assert property (!ctrlWrite |=> $stable(ctrl_reg))
    else $error("control changed without write");

  // A strobe with capture disabled changes nothing.
  capture_off_a : assert property (exitStrobe && !captureEn |=> $stable(infoWord) && !infoValid)
    else $error("strobe taken while capture disabled");

  // A clear without a competing set empties the flag.
  bad_clear_a : assert property (badClear && !(captureNow && anyBad) |=> !bad_reg)
    else $error("bad flag not cleared");

  // The flag holds when neither set nor clear.
  bad_hold_a : assert property (!badClear && !(captureNow && anyBad) |=> $stable(bad_reg))
    else $error("bad flag changed by itself");

  // Narrow parts never report extended index or base registers.
  narrow_regs_a : assert property (captureNow && !wideCapable |=>
    !infoWord[21] && !infoWord[26]) else $error("extended register on narrow part");

  // Narrow parts never report scaling by eight.
  narrow_scale_a : assert property (captureNow && !wideCapable |=>
    infoWord[1:0] != 2'h3) else $error("scale by eight on narrow part");

  // Narrow parts never report an extended second register.
  narrow_second_register_field_a : assert property (capInval && !wideCapable |=>
    !infoWord[31]) else $error("extended second register on narrow part");

  // Legal segment codes pass unchanged.
  seg_pass_a : assert property (captureNow && decIn.segment <= 3'h5 |=>
    infoWord[17:15] == $past(decIn.segment)) else $error("segment code altered");

  // Legal narrow address sizes pass unchanged.
  asize_pass_a : assert property (captureNow && decIn.addrSize < 2'h2 |=>
    infoWord[9:7] == {1'b0, $past(decIn.addrSize)}) else $error("address size altered");

  // Without zeroing, an absent index still passes its raw number.
  index_raw_a : assert property (capFull && !zeroUndef && !decIn.indexValid |=>
    infoWord[21:18] == $past(decIn.index_register_field)) else $error("raw index field lost");

  // Without zeroing, an absent base still passes its raw number.
  base_raw_a : assert property (capFull && !zeroUndef && !decIn.baseValid |=>
    infoWord[26:23] == $past(decIn.base_register_field)) else $error("raw base field lost");

  // Unused bits of the descriptor layout stay zero.
  dtab_spare_a : assert property (capDtab |=> infoWord[6:2] == 5'h0 &&
    infoWord[14:12] == 3'h0) else $error("descriptor spare bits set");

  // Unused bits of the invalidation layout stay zero.
  inval_spare_a : assert property (capInval |=> infoWord[6:2] == 5'h0 &&
    infoWord[14:10] == 5'h0) else $error("invalidation spare bits set");

  // Long-mode operand size is zeroed under control.
  op_quiet_a : assert property (capDtab && longMode && zeroUndef |=>
    !infoWord[11]) else $error("long mode operand size not zero");

  // The layout bit holds between captures.
  layout_hold_a : assert property (!captureNow |=> $stable(layout_reg))
    else $error("layout bit changed without exit");

endmodule : eie_exit_instr_info_encoder

//--- eie_exit_instr_info_encoder_tb.sv
// Holds the self-checking bench of the exit information encoder.
// Assumes the package, the constants header and the encoder are compiled before it.
`include "eie_defs.svh"

module eie_exit_instr_info_encoder_tb
  import eie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    eie_dec_type d;
    logic        lm;
    logic        wide;
    logic [31:0] exp;
  } eie_row_type;

  logic        ref_clk;
  logic        reset       = 1'b1;
  logic        exitStrobe  = 1'b0;
  logic        longMode    = 1'b0;
  logic        wideCapable = 1'b1;
  eie_dec_type decIn       = '0;
  logic        wb_cyc      = 1'b0;
  logic        wb_stb      = 1'b0;
  logic        wb_we       = 1'b0;
  logic [3:0]  wb_adr      = 4'h0;
  logic [3:0]  wb_sel      = 4'h0;
  logic [31:0] wb_wdat     = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [31:0] infoWord;
  logic        infoValid;
  logic [31:0] rdData;
  int          failures    = 0;
  int          checkCount  = 0;
  int          cycles      = 0;
  eie_row_type rows [8];
  eie_row_type raw;

  eie_exit_instr_info_encoder i_dut (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .exitStrobe (exitStrobe),
    .decIn      (decIn),
    .longMode   (longMode),
    .wideCapable(wideCapable),
    .wb_cyc_i   (wb_cyc),
    .wb_stb_i   (wb_stb),
    .wb_we_i    (wb_we),
    .wb_adr_i   (wb_adr),
    .wb_sel_i   (wb_sel),
    .wb_dat_i   (wb_wdat),
    .wb_dat_o   (wb_rdat),
    .wb_ack_o   (wb_ack),
    .infoWord   (infoWord),
    .infoValid  (infoValid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares a word and counts the outcome.
  task checkWord(input string name, input logic [31:0] expv, input logic [31:0] got);
    checkCount++;
    if (got !== expv) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, expv, got);
    end
  endtask : checkWord

  // Compares a single flag and counts the outcome.
  task checkBit(input string name, input logic expv, input logic got);
    checkCount++;
    if (got !== expv) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", name, expv, got);
    end
  endtask : checkBit

  // One classic Wishbone cycle, held until ack is sampled high; read data lands in rdData.
  task wbXfer(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel;
    wb_wdat <= dat;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      failures++;
      $display("MISMATCH wb_ack expected 1 seen %b", wb_ack);
    end
    rdData = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wbXfer

  // Presents one exit for a single cycle and checks the answer one cycle later.
  task capt(input eie_row_type r, input logic expValid);
    @(posedge ref_clk);
    exitStrobe  <= 1'b1;
    decIn       <= r.d;
    longMode    <= r.lm;
    wideCapable <= r.wide;
    @(posedge ref_clk);
    exitStrobe <= 1'b0;
    #1;
    checkBit("infoValid", expValid, infoValid);
    if (expValid) checkWord("infoWord", r.exp, infoWord);
  endtask : capt

  // Marks the end of a test.
  task endTest(input string name);
    $display("test %s done", name);
  endtask : endTest

  // Prints the counts and the verdict, then stops.
  task give_verdict();
    $display("comparisons %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of exits back to back, then status, control and reset cases.
  initial begin
    rows = '{
      '{'{EIE_LAYOUT_DTAB, EIE_STORE_GLOBAL_TABLE_INSTR, 2'h1, 2'h1, 1'h1, 3'h3, 4'h5, 1'h1, 4'hc, 1'h1, 4'h0},
        1'h0, 1'h1, 32'h06158881},
      '{'{EIE_LAYOUT_DTAB, EIE_STORE_INTERRUPT_TABLE_INSTR, 2'h3, 2'h2, 1'h1, 3'h5, 4'hf, 1'h1, 4'h0, 1'h1, 4'h0},
        1'h1, 1'h1, 32'h103e8103},
      '{'{EIE_LAYOUT_DTAB, EIE_LOAD_GLOBAL_TABLE_INSTR, 2'h2, 2'h0, 1'h1, 3'h0, 4'h7, 1'h0, 4'h8, 1'h1, 4'h0},
        1'h0, 1'h1, 32'h24400800},
      '{'{EIE_LAYOUT_DTAB, EIE_LOAD_INTERRUPT_TABLE_INSTR, 2'h1, 2'h1, 1'h0, 3'h2, 4'h3, 1'h1, 4'h9, 1'h0, 4'h0},
        1'h0, 1'h1, 32'h380d0081},
      '{'{EIE_LAYOUT_INVAL, EIE_STORE_GLOBAL_TABLE_INSTR, 2'h0, 2'h2, 1'h1, 3'h4, 4'ha, 1'h1, 4'h6, 1'h1, 4'hd},
        1'h0, 1'h1, 32'hd32a0100},
      '{'{EIE_LAYOUT_INVAL, EIE_STORE_GLOBAL_TABLE_INSTR, 2'h3, 2'h1, 1'h0, 3'h1, 4'h4, 1'h0, 4'h4, 1'h0, 4'h7},
        1'h0, 1'h1, 32'h78408080},
      '{'{EIE_LAYOUT_DTAB, EIE_STORE_GLOBAL_TABLE_INSTR, 2'h3, 2'h2, 1'h1, 3'h6, 4'h9, 1'h1, 4'he, 1'h1, 4'h0},
        1'h0, 1'h0, 32'h03040800},
      '{'{EIE_LAYOUT_INVAL, EIE_STORE_GLOBAL_TABLE_INSTR, 2'h0, 2'h3, 1'h0, 3'h7, 4'h0, 1'h0, 4'h0, 1'h0, 4'hf},
        1'h0, 1'h1, 32'hf8400000}};
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    checkWord("infoWord", 32'h0, infoWord);
    checkBit("infoValid", 1'b0, infoValid);
    wbXfer(1'b0, `EIE_OFS_CTRL, 4'h0, 32'h0);
    checkWord("ctrl", 32'h3, rdData);
    wbXfer(1'b0, `EIE_OFS_STATUS, 4'h0, 32'h0);
    checkWord("status", 32'h0, rdData);
    endTest("reset");
    for (int i = 0; i <= 8; i++) begin
      @(posedge ref_clk);
      exitStrobe <= (i < 8);
      if (i < 8) begin
        decIn       <= rows[i].d;
        longMode    <= rows[i].lm;
        wideCapable <= rows[i].wide;
      end
      #1;
      if (i > 0) begin
        checkBit("infoValid", 1'b1, infoValid);
        checkWord("infoWord", rows[i-1].exp, infoWord);
      end
    end
    endTest("table");
    wbXfer(1'b0, `EIE_OFS_STATUS, 4'h0, 32'h0);
    checkWord("status", 32'h00000801, rdData);
    wbXfer(1'b1, `EIE_OFS_STATUS, 4'h1, 32'h1);
    wbXfer(1'b0, `EIE_OFS_STATUS, 4'h0, 32'h0);
    checkWord("status", 32'h00000800, rdData);
    wbXfer(1'b0, `EIE_OFS_INFO, 4'h0, 32'h0);
    checkWord("info", 32'hf8400000, rdData);
    wbXfer(1'b0, 4'hc, 4'h0, 32'h0);
    checkWord("unmapped", 32'h0, rdData);
    endTest("status");
    wbXfer(1'b1, `EIE_OFS_CTRL, 4'h0, 32'h0);
    wbXfer(1'b0, `EIE_OFS_CTRL, 4'h0, 32'h0);
    checkWord("ctrl", 32'h3, rdData);
    wbXfer(1'b1, `EIE_OFS_CTRL, 4'h1, 32'h1);
    raw = rows[2];
    raw.exp = 32'h245c0802;
    capt(raw, 1'b1);
    wbXfer(1'b1, `EIE_OFS_CTRL, 4'h1, 32'h0);
    capt(rows[0], 1'b0);
    wbXfer(1'b0, `EIE_OFS_INFO, 4'h0, 32'h0);
    checkWord("info", 32'h245c0802, rdData);
    endTest("control");
    @(posedge ref_clk);
    reset <= 1'b1;
    #1;
    checkWord("infoWord", 32'h0, infoWord);
    @(posedge ref_clk);
    reset <= 1'b0;
    wbXfer(1'b0, `EIE_OFS_CTRL, 4'h0, 32'h0);
    checkWord("ctrl", 32'h3, rdData);
    endTest("second reset");
    give_verdict();
  end

endmodule : eie_exit_instr_info_encoder_tb

//--- eie_pkg.sv
// Holds the types of the exit information encoder.
// Assumes the constants header is on the include path.
`include "eie_defs.svh"

package eie_pkg;

  // Which word layout an exit selects.
  typedef enum logic {
    EIE_LAYOUT_INVAL,
    EIE_LAYOUT_DTAB
  } eie_layout_type;

  // Identity of a descriptor-table instruction, in its encoded order.
  typedef enum logic [1:0] {
    EIE_STORE_GLOBAL_TABLE_INSTR,
    EIE_STORE_INTERRUPT_TABLE_INSTR,
    EIE_LOAD_GLOBAL_TABLE_INSTR,
    EIE_LOAD_INTERRUPT_TABLE_INSTR
  } eie_dtab_instr_type;

  // Decoded operand information handed over at an exit.
  typedef struct packed {
    eie_layout_type     layout;
    eie_dtab_instr_type dtabInstr;
    logic [1:0]         scale;
    logic [1:0]         addrSize;
    logic               opSize32;
    logic [2:0]         segment;
    logic [3:0]         index_register_field;
    logic               indexValid;
    logic [3:0]         base_register_field;
    logic               baseValid;
    logic [3:0]         second_register_field;
  } eie_dec_type;

endpackage : eie_pkg
